// *** design/fsp_pkg.sv ***
package fsp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  // internal status write cycle length, plain default
  localparam int SR_WRITE_TIME_NS = 10000;
  localparam int SR_WRITE_CYCLES = (SR_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_TIMER_W = 11;
  localparam logic [SR_TIMER_W-1:0] SR_TIMER_LOAD = SR_WRITE_CYCLES[SR_TIMER_W-1:0];
  localparam logic [SR_TIMER_W-1:0] SR_TIMER_ONE = 11'h001;

  //////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] FOUR_LANE_PAGE_WRITE_CMD = 8'h32;
  localparam logic [7:0] SMALL_UNIT_WIPE_CMD = 8'h20;
  localparam logic [7:0] MID_UNIT_WIPE_CMD = 8'h52;
  localparam logic [7:0] LARGE_UNIT_WIPE_CMD = 8'hD8;
  localparam logic [7:0] CHIP_WIPE_CMD_A = 8'hC7;
  localparam logic [7:0] CHIP_WIPE_CMD_B = 8'h60;
  localparam logic [7:0] QUAD_MODE_ENTER_CMD = 8'h38;
  localparam logic [7:0] QUAD_MODE_EXIT_CMD = 8'hFF;
  localparam logic [7:0] OTP_MODE_ENTER_CMD = 8'h3A;

  //////////////////////////////////////////////////////////////////////////////
  // frame lengths in serial clocks
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  localparam logic [CNT_W-1:0] BITS_OPCODE = 6'h08;
  localparam logic [CNT_W-1:0] BITS_STATUS_WRITE = 6'h10;
  localparam logic [CNT_W-1:0] BITS_ADDR_CMD = 6'h20;
  localparam logic [CNT_W-1:0] BITS_PAGE_MIN = 6'h28;

  //////////////////////////////////////////////////////////////////////////////
  // status byte field positions
  localparam int SR_LOCK_POS = 7;
  localparam int SR_BOOT_EN_POS = 6;
  localparam int SR_PROT_LO = 2;
  localparam int SR_PROT_HI = 5;
  localparam int SR_CPDIS_POS = 6;
  localparam int SR_HRSEL_POS = 5;
  localparam int SR_GRAN_POS = 4;
  localparam int SR_TB_POS = 3;
  localparam int SR_WEL_POS = 1;
  localparam int SR_BUSY_POS = 0;

  // boot-lock address compare: 64KB block at [23:16], 4KB sector at [23:12]
  localparam logic [7:0] BLOCK_TOP = 8'hFF;
  localparam logic [7:0] BLOCK_BOTTOM = 8'h00;
  localparam logic [11:0] SECTOR_TOP = 12'hFFF;
  localparam logic [11:0] SECTOR_BOTTOM = 12'h000;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic status_lock_bit;
    logic boot_lock_enable;
    logic [3:0] protect_level;
  } fsp_nv_s;

  typedef struct packed {
    logic otp_lock;
    logic control_pins_disable;
    logic hold_reset_select;
    logic boot_lock_granularity;
    logic top_bottom_select;
  } fsp_otp_s;

  typedef enum logic [2:0] {
    OP_PAGE, OP_FOUR_LANE_PAGE, OP_SMALL_WIPE, OP_MID_WIPE, OP_LARGE_WIPE, OP_CHIP_WIPE
  } fsp_op_e;

  typedef struct packed {
    fsp_op_e kind;
    logic otp_sector;
    logic [23:0] addr;
  } fsp_op_s;

  localparam fsp_nv_s NV_RESET = '{1'b0, 1'b0, 4'h0};
  localparam fsp_otp_s OTP_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam fsp_op_s OP_RESET = '{OP_PAGE, 1'b0, 24'h000000};

endpackage

// *** design/fsp_status_regs.sv ***
`timescale 1ns/100ps

// Function
// - write disable clears latch, leaves OTP mode
// - latch cleared at reset and op completion
// - status read answered even while busy
// - status byte repeats while clocking continues
// - normal mode status byte bit map
// - OTP mode status byte bit map
// - busy high during write, program, erase
// - latch zero refuses writes, programs, erases
// - protected region refuses program and erase
// - protect bits writable unless hardware protected
// - chip erase needs zero protect, boot lock
// - boot lock guards chosen sector or block
// - lock bit plus low pin rejects status write
// - top/bottom places protected areas, OTP writable
// - granularity picks 4KB sector or 64KB block
// - pin disable bit turns off pin functions
// - shared pin is hold or reset
// - OTP lock set once, then guards OTP
// - write enable sets the latch
module fsp_status_regs (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // serial link pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic wp_n,
  input wire logic hold_reset_n,
  // array engine
  output logic op_start,
  output fsp_pkg::fsp_op_s op_req,
  input wire logic op_done,
  input wire logic bp_region_hit,
  // state for the protect table and the system
  output fsp_pkg::fsp_nv_s nv_bits,
  output fsp_pkg::fsp_otp_s otp_bits,
  output logic busy,
  output logic write_enable_latch,
  output logic otp_mode,
  output logic quad_mode,
  output logic hold_active,
  output logic pin_reset_req
);

  typedef enum logic [1:0] {ST_IDLE, ST_OPCODE, ST_STATUS, ST_COLLECT} fsp_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 1 is read only by stage 2
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic sclk_prev_q;
  logic cs_prev_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // idle pin levels: clock low, select high, data low, both control pins high
      sync1_q <= 5'h0B;
      sync2_q <= 5'h0B;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {spi_sclk, spi_cs_n, spi_mosi, wp_n, hold_reset_n};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[4];
      cs_prev_q <= sync2_q[3];
    end
  end

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic wp_n_s;
  logic hr_n_s;
  assign sclk_s = sync2_q[4];
  assign cs_n_s = sync2_q[3];
  assign mosi_s = sync2_q[2];
  assign wp_n_s = sync2_q[1];
  assign hr_n_s = sync2_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // shared pin functions; quad framing takes both pins away
  logic pins_on;
  logic hw_protected;
  logic hold_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  fsp_pkg::fsp_nv_s nv_q;
  fsp_pkg::fsp_otp_s otp_q;
  logic quad_q;

  assign pins_on = ~otp_q.control_pins_disable & ~quad_q;
  assign hw_protected = nv_q.status_lock_bit & pins_on & ~wp_n_s;
  assign hold_d = pins_on & ~otp_q.hold_reset_select & ~hr_n_s;
  // held clocks are ignored rather than queued, as the pin means
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s & ~hold_active;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s & ~hold_active;
  assign cs_rise = cs_n_s & ~cs_prev_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_active <= 1'b0;
      pin_reset_req <= 1'b0;
    end else begin
      hold_active <= hold_d;
      pin_reset_req <= pins_on & otp_q.hold_reset_select & ~hr_n_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame capture: opcode, first data byte, 24-bit address
  fsp_state_e state_q;
  logic [fsp_pkg::CNT_W-1:0] cnt_q;
  logic [23:0] sh_q;
  logic [7:0] opcode_q;
  logic [7:0] data_q;
  logic [23:0] addr_q;
  logic [7:0] next_byte;
  assign next_byte = {sh_q[6:0], mosi_s};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      sh_q <= 24'h000000;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (cs_n_s) begin
      cnt_q <= '0;
    end else if (sclk_rise) begin
      // long frames wrap inside the last byte so byte boundaries keep coming
      if (cnt_q != fsp_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end else begin
        cnt_q <= fsp_pkg::CNT_MAX - 6'h07;
      end
      sh_q <= {sh_q[22:0], mosi_s};
      if (cnt_q == 6'h07) begin
        opcode_q <= next_byte;
      end
      if (cnt_q == 6'h0F) begin
        data_q <= next_byte;
      end
      if (cnt_q == 6'h1F) begin
        addr_q <= {sh_q[22:0], mosi_s};
      end
    end
  end

  // frame state; status read is served whatever the busy state is
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else if (cs_n_s) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_OPCODE;
        end
        ST_OPCODE: begin
          if (sclk_rise && cnt_q == 6'h07) begin
            state_q <= (next_byte == fsp_pkg::STATUS_READ_CMD) ? ST_STATUS : ST_COLLECT;
          end
        end
        ST_STATUS: begin
          state_q <= ST_STATUS;
        end
        ST_COLLECT: begin
          state_q <= ST_COLLECT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status byte views
  logic [7:0] status_byte;

  always_comb begin
    if (otp_mode) begin
      status_byte = {otp_q.otp_lock, otp_q.control_pins_disable, otp_q.hold_reset_select,
                     otp_q.boot_lock_granularity, otp_q.top_bottom_select, 1'b0,
                     write_enable_latch, busy};
    end else begin
      status_byte = {nv_q.status_lock_bit, nv_q.boot_lock_enable, nv_q.protect_level,
                     write_enable_latch, busy};
    end
  end

  // output shifter: reload the live byte at every byte boundary
  logic [6:0] out_sh_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      out_sh_q <= 7'h00;
    end else if (state_q != ST_STATUS) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (sclk_fall) begin
      spi_miso_oe <= 1'b1;
      if (cnt_q[2:0] == 3'h0) begin
        spi_miso <= status_byte[7];
        out_sh_q <= status_byte[6:0];
      end else begin
        spi_miso <= out_sh_q[6];
        out_sh_q <= {out_sh_q[5:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode at the end of a frame
  logic at_opcode;
  logic whole_bytes;
  logic cmd_ok;
  logic is_wipe;
  logic is_page;
  logic is_chip;
  logic boot_hit;
  logic array_go;
  logic sr_go;
  fsp_pkg::fsp_op_e kind_d;

  assign at_opcode = cnt_q == fsp_pkg::BITS_OPCODE;
  assign whole_bytes = cnt_q[2:0] == 3'h0;
  // nothing but status read is acted on while a cycle runs
  assign cmd_ok = cs_rise && state_q == ST_COLLECT && !busy;
  assign is_page = (opcode_q == fsp_pkg::PAGE_WRITE_CMD ||
                    opcode_q == fsp_pkg::FOUR_LANE_PAGE_WRITE_CMD) &&
                   cnt_q >= fsp_pkg::BITS_PAGE_MIN && whole_bytes;
  assign is_wipe = (opcode_q == fsp_pkg::SMALL_UNIT_WIPE_CMD ||
                    opcode_q == fsp_pkg::MID_UNIT_WIPE_CMD ||
                    opcode_q == fsp_pkg::LARGE_UNIT_WIPE_CMD) &&
                   cnt_q == fsp_pkg::BITS_ADDR_CMD;
  assign is_chip = (opcode_q == fsp_pkg::CHIP_WIPE_CMD_A ||
                    opcode_q == fsp_pkg::CHIP_WIPE_CMD_B) && at_opcode;

  // boot area follows top/bottom and granularity
  always_comb begin
    if (otp_q.boot_lock_granularity) begin
      boot_hit = addr_q[23:12] == (otp_q.top_bottom_select ? fsp_pkg::SECTOR_BOTTOM :
                                   fsp_pkg::SECTOR_TOP);
    end else begin
      boot_hit = addr_q[23:16] == (otp_q.top_bottom_select ? fsp_pkg::BLOCK_BOTTOM :
                                   fsp_pkg::BLOCK_TOP);
    end
  end

  always_comb begin
    unique case (opcode_q)
      fsp_pkg::FOUR_LANE_PAGE_WRITE_CMD: kind_d = fsp_pkg::OP_FOUR_LANE_PAGE;
      fsp_pkg::SMALL_UNIT_WIPE_CMD: kind_d = fsp_pkg::OP_SMALL_WIPE;
      fsp_pkg::MID_UNIT_WIPE_CMD: kind_d = fsp_pkg::OP_MID_WIPE;
      fsp_pkg::LARGE_UNIT_WIPE_CMD: kind_d = fsp_pkg::OP_LARGE_WIPE;
      fsp_pkg::CHIP_WIPE_CMD_A, fsp_pkg::CHIP_WIPE_CMD_B: kind_d = fsp_pkg::OP_CHIP_WIPE;
      default: kind_d = fsp_pkg::OP_PAGE;
    endcase
  end

  always_comb begin
    array_go = 1'b0;
    if (cmd_ok && write_enable_latch) begin
      if (otp_mode) begin
        array_go = (is_page || is_wipe) && !otp_q.otp_lock;
      end else if (is_chip) begin
        array_go = nv_q.protect_level == 4'h0 && !nv_q.boot_lock_enable;
      end else if (is_page || is_wipe) begin
        array_go = !bp_region_hit && !(nv_q.boot_lock_enable && boot_hit);
      end
    end
  end

  assign sr_go = cmd_ok && write_enable_latch && !hw_protected &&
                 opcode_q == fsp_pkg::STATUS_WRITE_CMD &&
                 cnt_q >= fsp_pkg::BITS_STATUS_WRITE && whole_bytes;

  //////////////////////////////////////////////////////////////////////////////
  // engine request; refused requests never reach the engine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op_start <= 1'b0;
      op_req <= fsp_pkg::OP_RESET;
    end else begin
      op_start <= array_go;
      if (array_go) begin
        op_req <= '{kind_d, otp_mode, addr_q};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // busy: status write timer and engine cycle
  logic [fsp_pkg::SR_TIMER_W-1:0] sr_timer_q;
  logic eng_busy_q;
  logic sr_end;
  logic eng_end;
  assign sr_end = sr_timer_q == fsp_pkg::SR_TIMER_ONE;
  assign eng_end = eng_busy_q && op_done;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sr_timer_q <= '0;
      eng_busy_q <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (sr_go) begin
        sr_timer_q <= fsp_pkg::SR_TIMER_LOAD;
      end else if (sr_timer_q != '0) begin
        sr_timer_q <= sr_timer_q - fsp_pkg::SR_TIMER_ONE;
      end
      if (array_go) begin
        eng_busy_q <= 1'b1;
      end else if (op_done) begin
        eng_busy_q <= 1'b0;
      end
      busy <= sr_go || array_go || (sr_timer_q != '0 && !sr_end) ||
              (eng_busy_q && !op_done);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write enable latch and mode flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_latch <= 1'b0;
      otp_mode <= 1'b0;
      quad_q <= 1'b0;
    end else begin
      if (sr_end || eng_end) begin
        write_enable_latch <= 1'b0;
      end else if (cmd_ok && at_opcode && opcode_q == fsp_pkg::WRITE_DISABLE_CMD) begin
        write_enable_latch <= 1'b0;
      end else if (cmd_ok && at_opcode && opcode_q == fsp_pkg::WRITE_ENABLE_CMD) begin
        write_enable_latch <= 1'b1;
      end
      if (cmd_ok && at_opcode && opcode_q == fsp_pkg::WRITE_DISABLE_CMD) begin
        otp_mode <= 1'b0;
      end else if (cmd_ok && at_opcode && opcode_q == fsp_pkg::OTP_MODE_ENTER_CMD) begin
        otp_mode <= 1'b1;
      end
      if (cmd_ok && at_opcode && opcode_q == fsp_pkg::QUAD_MODE_ENTER_CMD) begin
        quad_q <= 1'b1;
      end else if (cmd_ok && at_opcode && opcode_q == fsp_pkg::QUAD_MODE_EXIT_CMD) begin
        quad_q <= 1'b0;
      end
    end
  end

  assign quad_mode = quad_q;

  //////////////////////////////////////////////////////////////////////////////
  // status bits: the view in force picks which bits a status write reaches
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nv_q <= fsp_pkg::NV_RESET;
      otp_q <= fsp_pkg::OTP_RESET;
    end else if (sr_go && !otp_mode) begin
      nv_q <= '{data_q[fsp_pkg::SR_LOCK_POS], data_q[fsp_pkg::SR_BOOT_EN_POS],
                data_q[fsp_pkg::SR_PROT_HI:fsp_pkg::SR_PROT_LO]};
    end else if (sr_go) begin
      // lock only ever goes one way
      otp_q <= '{otp_q.otp_lock | data_q[fsp_pkg::SR_LOCK_POS],
                 data_q[fsp_pkg::SR_CPDIS_POS], data_q[fsp_pkg::SR_HRSEL_POS],
                 data_q[fsp_pkg::SR_GRAN_POS], data_q[fsp_pkg::SR_TB_POS]};
    end
  end

  assign nv_bits = nv_q;
  assign otp_bits = otp_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_busy_run;
    busy [*8];
  endsequence

  property p_write_disable_cmd;
    @(posedge clock) disable iff (!arst_n)
    (cmd_ok && at_opcode && opcode_q == fsp_pkg::WRITE_DISABLE_CMD) |=>
      !write_enable_latch && !otp_mode;
  endproperty
  a_write_disable_cmd: assert property (p_write_disable_cmd) else $error("write disable left latch or mode");

  property p_wel_done;
    @(posedge clock) disable iff (!arst_n) (sr_end || eng_end) |=> !write_enable_latch;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after completion");

  property p_status_bit7;
    @(posedge clock) disable iff (!arst_n)
    (state_q == ST_STATUS && sclk_fall && cnt_q[2:0] == 3'h0) |=>
      spi_miso == $past(status_byte[7]) && spi_miso_oe;
  endproperty
  a_status_bit7: assert property (p_status_bit7) else $error("status msb not driven");

  property p_normal_map;
    @(posedge clock) disable iff (!arst_n)
    !otp_mode |-> status_byte[fsp_pkg::SR_PROT_HI:fsp_pkg::SR_PROT_LO] == nv_q.protect_level &&
      status_byte[fsp_pkg::SR_BUSY_POS] == busy;
  endproperty
  a_normal_map: assert property (p_normal_map) else $error("normal status map wrong");

  property p_sr_busy;
    @(posedge clock) disable iff (!arst_n) sr_go |=> s_busy_run;
  endproperty
  a_sr_busy: assert property (p_sr_busy) else $error("busy not held in status write");

  property p_no_wel;
    @(posedge clock) disable iff (!arst_n)
    (cs_rise && !write_enable_latch && !busy) |=> !op_start && !busy;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("operation taken without latch");

  property p_chip;
    @(posedge clock) disable iff (!arst_n)
    (op_start && op_req.kind == fsp_pkg::OP_CHIP_WIPE) |->
      $past(nv_q.protect_level) == 4'h0 && !$past(nv_q.boot_lock_enable);
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase while protected");

  property p_hw_lock;
    @(posedge clock) disable iff (!arst_n) hw_protected |=> $stable(nv_q);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("status changed while locked");

  property p_otp_lock;
    @(posedge clock) disable iff (!arst_n)
    otp_q.otp_lock |=> otp_q.otp_lock && !(array_go && otp_mode);
  endproperty
  a_otp_lock: assert property (p_otp_lock) else $error("otp lock cleared or bypassed");

  property p_boot;
    @(posedge clock) disable iff (!arst_n)
    (array_go && !otp_mode && nv_q.boot_lock_enable) |-> !boot_hit;
  endproperty
  a_boot: assert property (p_boot) else $error("boot area modified");

endmodule

// *** dv/fsp_host_model.sv ***
`timescale 1ns/100ps

// host side of the serial link, mode 0, one frame per call
module fsp_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // serial clock half period, 125 ns link period
  localparam real HALF = 62.5;

  // serial clock stands low and chip select high outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one bit: data set while sclk low, sampled by both sides on the rise
  task automatic one_bit(input logic d, output logic v);
    mosi = d;
    #HALF sclk = 1'b1;
    v = miso;
    #HALF sclk = 1'b0;
  endtask

  // chip select low, whole bytes msb first, nrx bytes read back, chip select high
  task automatic frame(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
    logic [7:0] b;
    logic v;
    rx = {};
    cs_n = 1'b0;
    #HALF;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        one_bit(tx[i][k], v);
      end
    end
    for (int n = 0; n < nrx; n++) begin
      for (int k = 7; k >= 0; k--) begin
        one_bit(~mosi, v);
        b[k] = v;
      end
      rx.push_back(b);
    end
    #HALF cs_n = 1'b1;
    // released data line must not look like it still holds the last bit
    mosi = ~mosi;
    #200;
  endtask
endmodule

// *** dv/fsp_status_regs_bench.sv ***
`timescale 1ns/100ps

module fsp_status_regs_bench;
  logic clock, arst_n, wp_n, hold_reset_n, op_done, bp_region_hit;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, op_start, busy;
  logic write_enable_latch, otp_mode, quad_mode, hold_active, pin_reset_req;
  fsp_pkg::fsp_op_s op_req;
  fsp_pkg::fsp_nv_s nv_bits;
  fsp_pkg::fsp_otp_s otp_bits;
  int fail_count, total_checks, starts;
  logic [7:0] rx[$];

  fsp_status_regs i_fsp_status_regs (.clock(clock), .arst_n(arst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .wp_n(wp_n), .hold_reset_n(hold_reset_n), .op_start(op_start), .op_req(op_req),
    .op_done(op_done), .bp_region_hit(bp_region_hit), .nv_bits(nv_bits), .otp_bits(otp_bits),
    .busy(busy), .write_enable_latch(write_enable_latch), .otp_mode(otp_mode),
    .quad_mode(quad_mode), .hold_active(hold_active), .pin_reset_req(pin_reset_req));
  fsp_host_model i_fsp_host_model (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso));

  // 8 ns system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // engine start pulses are counted, a refused command must leave the count alone
  // sampled mid-cycle so each one-cycle pulse is seen exactly once
  always @(negedge clock) begin
    if (op_start === 1'b1) starts++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] tx[$]);
    i_fsp_host_model.frame(tx, 0, rx);
  endtask

  // bounded wait on the busy level, 1250 cycle write plus margin
  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clock);
    check("busy after wait", busy, 0);
  endtask

  task automatic status_write(input logic [7:0] v);
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::STATUS_WRITE_CMD, v});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_latch();
    i_fsp_host_model.frame('{fsp_pkg::STATUS_READ_CMD}, 2, rx);
    check("status after reset", {rx[0], rx[1]}, 16'h0000);
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    i_fsp_host_model.frame('{fsp_pkg::STATUS_READ_CMD}, 1, rx);
    check("status latch set", rx[0], 8'h02);
    cmd('{fsp_pkg::WRITE_DISABLE_CMD});
    check("latch after disable", write_enable_latch, 0);
    cmd('{fsp_pkg::STATUS_WRITE_CMD, 8'h3C});
    check("busy on refused write", busy, 0);
    check("bits on refused write", nv_bits, 6'h00);
    $display("test reset_latch done");
  endtask

  // status read while the write cycle runs, eight bytes back to back
  task automatic t_status_write();
    status_write(8'h3C);
    i_fsp_host_model.frame('{fsp_pkg::STATUS_READ_CMD}, 8, rx);
    check("status while busy", {rx[0], rx[7]}, 16'h3F3F);
    wait_idle();
    i_fsp_host_model.frame('{fsp_pkg::STATUS_READ_CMD}, 1, rx);
    check("status after write", rx[0], 8'h3C);
    $display("test status_write done");
  endtask

  task automatic t_protect();
    int s0;
    s0 = starts;
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::CHIP_WIPE_CMD_A});
    check("chip erase refused", starts - s0, 0);
    @(negedge clock) bp_region_hit = 1'b1;
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::SMALL_UNIT_WIPE_CMD, 8'h12, 8'h34, 8'h56});
    check("protected erase refused", starts - s0, 0);
    check("busy after refusal", busy, 0);
    @(negedge clock) bp_region_hit = 1'b0;
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::SMALL_UNIT_WIPE_CMD, 8'h12, 8'h34, 8'h56});
    check("erase started", starts - s0, 1);
    check("erase kind", op_req.kind, fsp_pkg::OP_SMALL_WIPE);
    check("erase addr", op_req.addr, 24'h123456);
    check("busy during erase", busy, 1);
    @(negedge clock) op_done = 1'b1;
    @(negedge clock) op_done = 1'b0;
    wait_idle();
    check("latch after erase", write_enable_latch, 0);
    $display("test protect done");
  endtask

  // lock bit with the pin low turns status write away entirely
  task automatic t_lock();
    status_write(8'h80);
    wait_idle();
    check("lock set", nv_bits, 6'h20);
    wp_n = 1'b0;
    status_write(8'h00);
    check("locked write busy", busy, 0);
    check("locked bits", nv_bits, 6'h20);
    wp_n = 1'b1;
    status_write(8'h00);
    wait_idle();
    check("unlocked write", nv_bits, 6'h00);
    $display("test lock done");
  endtask

  // reserved bit 2 written as one must read back zero
  task automatic t_otp();
    cmd('{fsp_pkg::OTP_MODE_ENTER_CMD});
    check("otp mode on", otp_mode, 1);
    status_write(8'h1C);
    wait_idle();
    i_fsp_host_model.frame('{fsp_pkg::STATUS_READ_CMD}, 1, rx);
    check("otp view", rx[0], 8'h18);
    check("otp bits", otp_bits, 5'h03);
    cmd('{fsp_pkg::WRITE_DISABLE_CMD});
    check("otp mode off", otp_mode, 0);
    $display("test otp done");
  endtask

  // shared pin acts as hold while enabled, and does nothing once quad framing is on
  task automatic t_pins();
    check("oe idle", spi_miso_oe, 0);
    @(negedge clock) hold_reset_n = 1'b0;
    repeat (4) @(negedge clock);
    check("hold on", {hold_active, pin_reset_req}, 2'b10);
    @(negedge clock) hold_reset_n = 1'b1;
    cmd('{fsp_pkg::QUAD_MODE_ENTER_CMD});
    check("quad on", quad_mode, 1);
    @(negedge clock) hold_reset_n = 1'b0;
    repeat (4) @(negedge clock);
    check("hold off in quad", {hold_active, pin_reset_req}, 2'b00);
    @(negedge clock) hold_reset_n = 1'b1;
    cmd('{fsp_pkg::QUAD_MODE_EXIT_CMD});
    check("quad off", quad_mode, 0);
    $display("test pins done");
  endtask

  // boot lock on the bottom sector, an OTP program, then the one-way OTP lock
  task automatic t_guard();
    int s0;
    s0 = starts;
    status_write(8'h40);
    wait_idle();
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::LARGE_UNIT_WIPE_CMD, 8'h00, 8'h0F, 8'hF0});
    check("boot sector refused", starts - s0, 0);
    cmd('{fsp_pkg::CHIP_WIPE_CMD_B});
    check("chip erase boot locked", starts - s0, 0);
    cmd('{fsp_pkg::OTP_MODE_ENTER_CMD});
    cmd('{fsp_pkg::PAGE_WRITE_CMD, 8'h00, 8'h00, 8'h00, 8'h5A});
    check("otp program", starts - s0, 1);
    check("otp sector", op_req.otp_sector, 1);
    @(negedge clock) op_done = 1'b1;
    @(negedge clock) op_done = 1'b0;
    wait_idle();
    status_write(8'hA0);
    wait_idle();
    cmd('{fsp_pkg::WRITE_ENABLE_CMD});
    cmd('{fsp_pkg::PAGE_WRITE_CMD, 8'h00, 8'h00, 8'h00, 8'h5A});
    check("otp locked program", starts - s0, 1);
    @(negedge clock) hold_reset_n = 1'b0;
    repeat (4) @(negedge clock);
    check("reset pin", {hold_active, pin_reset_req}, 2'b01);
    @(negedge clock) hold_reset_n = 1'b1;
    status_write(8'h00);
    wait_idle();
    check("otp lock kept", otp_bits, 5'h10);
    cmd('{fsp_pkg::WRITE_DISABLE_CMD});
    $display("test guard done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // the whole run takes about 150 us, so 300 us means a hang
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    hold_reset_n = 1'b1;
    op_done = 1'b0;
    bp_region_hit = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    repeat (6) @(negedge clock);
    t_reset_latch();
    t_status_write();
    t_protect();
    t_lock();
    t_otp();
    t_pins();
    t_guard();
    give_verdict();
  end
endmodule
